/* fdchr_pkg.sv */
// Constants, field layouts and carrier types for the floppy controller host registers
package fdchr_pkg;

    // Register offsets within the 8-byte window
    localparam logic [2:0] OFF_STATUS_A_PORT = 3'h0;
    localparam logic [2:0] OFF_STATUS_B_PORT = 3'h1;
    localparam logic [2:0] OFF_DIGITAL_OUTPUT_CTL = 3'h2;
    localparam logic [2:0] OFF_TAPE_DRIVE_CTL = 3'h3;
    localparam logic [2:0] OFF_MAIN_STATUS_RATE = 3'h4;
    localparam logic [2:0] OFF_COMMAND_DATA_FIFO = 3'h5;
    localparam logic [2:0] OFF_UNASSIGNED = 3'h6;
    localparam logic [2:0] OFF_DIGITAL_INPUT_CONFIG = 3'h7;
    localparam int WINDOW_BITS = 3;

    // Command byte
    localparam int CMD_MFM_BIT = 6;
    localparam int CMD_OPCODE_MSB = 4;
    localparam logic [4:0] OPC_READ_DATA = 5'h06;
    localparam logic [4:0] OPC_READ_DELETED = 5'h0C;
    localparam logic [4:0] OPC_WRITE_DATA = 5'h05;
    localparam logic [4:0] OPC_WRITE_DELETED = 5'h09;
    localparam logic [4:0] OPC_READ_TRACK = 5'h02;

    // Digital output control fields
    localparam int DOUT_MOTOR_LSB = 4;
    localparam int DOUT_DMA_BIT = 3;
    localparam int DOUT_RESET_N_BIT = 2;
    localparam int DOUT_SEL_LSB = 0;

    // Rate select fields
    localparam int RSEL_SOFT_RESET_BIT = 7;
    localparam int RSEL_LOW_POWER_BIT = 6;
    localparam int RSEL_PRECOMP_LSB = 2;
    localparam int RSEL_RATE_LSB = 0;

    // Tape drive control fields
    localparam int TAPE_EXCHANGE_LSB = 2;
    localparam int TAPE_SELECT_LSB = 0;

    // Reset values
    localparam logic [7:0] DOUT_RESET = 8'h00;
    localparam logic [1:0] TAPE_SEL_RESET = 2'h0;
    localparam logic [1:0] EXCHANGE_RESET = 2'h0;
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [2:0] PRECOMP_RESET = 3'h0;
    localparam logic LOW_POWER_RESET = 1'b0;
    localparam logic MFM_RESET = 1'b0;

    // Read values
    localparam logic [7:0] READ_FLOAT = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [5:0] RSVD_ZERO6 = 6'h00;
    localparam logic [3:0] RSVD_ZERO4 = 4'h0;
    localparam logic [1:0] RSVD_ZERO2 = 2'h0;

    // Drive pins, raw from the cable side
    typedef struct packed {
        logic index;
        logic trackZero;
        logic writeProtect;
        logic readData;
        logic diskChangedFlag;
        logic mediaSenseInA;
    } fdchr_pins_t;

    // Status from the command engine, same clock
    typedef struct packed {
        logic irqPending;
        logic step;
        logic headSelect;
        logic headDirection;
        logic writeData;
        logic writeGate;
        logic cmdIdle;
        logic [7:0] mainStatus;
        logic [7:0] fifoData;
    } fdchr_eng_t;

endpackage : fdchr_pkg

/* fdchr_sync.sv */
// Two-flop synchroniser for a vector of independent level inputs
`timescale 1ns/10ps
`default_nettype none
module fdchr_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;

    // Stage one feeds only stage two
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;
endmodule : fdchr_sync
`default_nettype wire

/* fdchr_regs.sv */
// Host register front end of the floppy disk controller
//
// Behaviour
// - Bit 6 of a read/write command first byte selects FM or MFM
// - Floated drive pins make every read 0xFF
// - Second media-sense input drives no logic
// - No upper data-rate output pin exists
// - Decode window is 8-byte aligned, low bits select
// - Offset 4 and 7 split read/write registers
// - Written fields behave alike in PC-AT and PS/2
// - Status A/B and full input only PS/2
// - PC-AT input read shows disk change only
// - Extended tape layout only in enhanced mode
`timescale 1ns/10ps
`default_nettype none
module fdchr_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] baseAddr,
    input wire logic [15:0] ioAddr,
    input wire logic ioRead,
    input wire logic ioWrite,
    input wire logic [7:0] ioWData,
    output logic [7:0] ioRData,
    output logic ioRValid,
    input wire logic ps2Mode,
    input wire logic enhancedTapeLayoutMode,
    input wire logic pinsFloat,
    input wire logic [1:0] driveId,
    input wire fdchr_pkg::fdchr_pins_t drivePins,
    input wire fdchr_pkg::fdchr_eng_t engine,
    output logic fifoWriteStrobe,
    output logic fifoReadStrobe,
    output logic [7:0] cmdByte,
    output logic mfmMode,
    output logic [3:0] motorEnable,
    output logic dmaEnable,
    output logic controllerReset_n,
    output logic [1:0] driveSelect,
    output logic [1:0] tapeSelect,
    output logic [1:0] driveExchange,
    output logic softReset,
    output logic lowPower,
    output logic [2:0] precompSelect,
    output logic lowerRateOut
);
    fdchr_pkg::fdchr_pins_t pinSync;

    // Pins cross from the cable side before use; the second sense input is not brought in
    fdchr_sync #(
        .W($bits(fdchr_pkg::fdchr_pins_t))
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn(drivePins),
        .syncOut(pinSync)
    );

    logic [7:0] dout_q;
    logic [1:0] tapeSel_q;
    logic [1:0] exchange_q;
    logic [1:0] rate_q;
    logic [2:0] precomp_q;
    logic lowPower_q;
    logic softReset_q;
    logic mfm_q;
    logic firstByte_q;
    logic [7:0] cmdByte_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    localparam int WINDOW_BITS_C = fdchr_pkg::WINDOW_BITS;

    // Decode
    wire windowHit = (ioAddr[15:WINDOW_BITS_C] == baseAddr[15:WINDOW_BITS_C]);
    wire [2:0] offset = ioAddr[2:0];
    wire rdHit = ioRead && windowHit;
    wire wrHit = ioWrite && windowHit;
    wire wrDout = wrHit && (offset == fdchr_pkg::OFF_DIGITAL_OUTPUT_CTL);
    wire wrTape = wrHit && (offset == fdchr_pkg::OFF_TAPE_DRIVE_CTL);
    wire wrRate = wrHit && (offset == fdchr_pkg::OFF_MAIN_STATUS_RATE);
    wire wrFifo = wrHit && (offset == fdchr_pkg::OFF_COMMAND_DATA_FIFO);
    wire wrConfig = wrHit && (offset == fdchr_pkg::OFF_DIGITAL_INPUT_CONFIG);
    wire rdFifo = rdHit && (offset == fdchr_pkg::OFF_COMMAND_DATA_FIFO);

    // Read/write command opcodes carry the density bit
    wire [4:0] opcode = ioWData[fdchr_pkg::CMD_OPCODE_MSB:0];
    wire isRwOpcode = (opcode == fdchr_pkg::OPC_READ_DATA)
        || (opcode == fdchr_pkg::OPC_READ_DELETED)
        || (opcode == fdchr_pkg::OPC_WRITE_DATA)
        || (opcode == fdchr_pkg::OPC_WRITE_DELETED)
        || (opcode == fdchr_pkg::OPC_READ_TRACK);
    wire mfmLoad = wrFifo && firstByte_q && isRwOpcode;

    // Read views; one layout in both system modes unless marked otherwise
    wire [7:0] statusAView = {engine.irqPending, 1'b0, engine.step, pinSync.trackZero,
        engine.headSelect, pinSync.index, pinSync.writeProtect, engine.headDirection};
    wire [7:0] statusBView = {fdchr_pkg::RSVD_ZERO2, dout_q[fdchr_pkg::DOUT_SEL_LSB],
        engine.writeData, pinSync.readData, engine.writeGate,
        dout_q[fdchr_pkg::DOUT_MOTOR_LSB + 1], dout_q[fdchr_pkg::DOUT_MOTOR_LSB]};
    wire [7:0] tapeEnhView = {1'b1, pinSync.mediaSenseInA, driveId, exchange_q,
        tapeSel_q};
    wire [7:0] tapePlainView = {fdchr_pkg::RSVD_ZERO6, tapeSel_q};
    wire [7:0] tapeView = enhancedTapeLayoutMode ? tapeEnhView : tapePlainView;
    // High density is low-active: low for the two fast rates
    wire densityLow = (rate_q == 2'h0) || (rate_q == 2'h3);
    wire [7:0] inputPs2View = {pinSync.diskChangedFlag, fdchr_pkg::RSVD_ZERO4,
        rate_q, ~densityLow};
    wire [7:0] inputAtView = {pinSync.diskChangedFlag, 7'h00};
    wire [7:0] inputView = ps2Mode ? inputPs2View : inputAtView;

    logic [7:0] readMux;
    always_comb begin
        readMux = fdchr_pkg::READ_FLOAT;
        unique case (offset)
            fdchr_pkg::OFF_STATUS_A_PORT: begin
                readMux = ps2Mode ? statusAView : fdchr_pkg::READ_FLOAT;
            end
            fdchr_pkg::OFF_STATUS_B_PORT: begin
                readMux = ps2Mode ? statusBView : fdchr_pkg::READ_FLOAT;
            end
            fdchr_pkg::OFF_DIGITAL_OUTPUT_CTL: begin
                readMux = dout_q;
            end
            fdchr_pkg::OFF_TAPE_DRIVE_CTL: begin
                readMux = tapeView;
            end
            fdchr_pkg::OFF_MAIN_STATUS_RATE: begin
                readMux = engine.mainStatus;
            end
            fdchr_pkg::OFF_COMMAND_DATA_FIFO: begin
                readMux = engine.fifoData;
            end
            fdchr_pkg::OFF_UNASSIGNED: begin
                readMux = fdchr_pkg::READ_FLOAT;
            end
            fdchr_pkg::OFF_DIGITAL_INPUT_CONFIG: begin
                readMux = inputView;
            end
        endcase
    end

    // Floating drive pins override every view
    wire [7:0] readValue = pinsFloat ? fdchr_pkg::READ_FLOAT : readMux;

    // Read answer, one cycle after the request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= fdchr_pkg::READ_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rdHit;
            if (rdHit) begin
                rdata_q <= readValue;
            end
        end
    end

    // Control registers; offset 6 reaches none of them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dout_q <= fdchr_pkg::DOUT_RESET;
            tapeSel_q <= fdchr_pkg::TAPE_SEL_RESET;
            exchange_q <= fdchr_pkg::EXCHANGE_RESET;
        end else begin
            if (wrDout) begin
                dout_q <= ioWData;
            end
            if (wrTape) begin
                tapeSel_q <= ioWData[fdchr_pkg::TAPE_SELECT_LSB +: 2];
                if (enhancedTapeLayoutMode) begin
                    exchange_q <= ioWData[fdchr_pkg::TAPE_EXCHANGE_LSB +: 2];
                end
            end
        end
    end

    // Rate is written from either rate register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_q <= fdchr_pkg::RATE_RESET;
            precomp_q <= fdchr_pkg::PRECOMP_RESET;
            lowPower_q <= fdchr_pkg::LOW_POWER_RESET;
            softReset_q <= 1'b0;
        end else begin
            softReset_q <= wrRate && ioWData[fdchr_pkg::RSEL_SOFT_RESET_BIT];
            if (wrRate) begin
                rate_q <= ioWData[fdchr_pkg::RSEL_RATE_LSB +: 2];
                precomp_q <= ioWData[fdchr_pkg::RSEL_PRECOMP_LSB +: 3];
                lowPower_q <= ioWData[fdchr_pkg::RSEL_LOW_POWER_BIT];
            end else if (wrConfig) begin
                rate_q <= ioWData[fdchr_pkg::RSEL_RATE_LSB +: 2];
            end
        end
    end

    // First-byte tracking: the engine marks idle between commands
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            firstByte_q <= 1'b1;
            mfm_q <= fdchr_pkg::MFM_RESET;
            cmdByte_q <= fdchr_pkg::READ_ZERO;
        end else begin
            if (wrFifo) begin
                firstByte_q <= 1'b0;
                cmdByte_q <= ioWData;
            end else if (engine.cmdIdle) begin
                firstByte_q <= 1'b1;
            end
            if (mfmLoad) begin
                mfm_q <= ioWData[fdchr_pkg::CMD_MFM_BIT];
            end
        end
    end

    // Outputs
    assign ioRData = rdata_q;
    assign ioRValid = rvalid_q;
    assign fifoWriteStrobe = wrFifo;
    // A floated read returns ones and must not pop the engine's data
    assign fifoReadStrobe = rdFifo && !pinsFloat;
    assign cmdByte = cmdByte_q;
    assign mfmMode = mfm_q;
    assign motorEnable = dout_q[fdchr_pkg::DOUT_MOTOR_LSB +: 4];
    assign dmaEnable = dout_q[fdchr_pkg::DOUT_DMA_BIT];
    assign controllerReset_n = dout_q[fdchr_pkg::DOUT_RESET_N_BIT];
    assign driveSelect = dout_q[fdchr_pkg::DOUT_SEL_LSB +: 2];
    assign tapeSelect = tapeSel_q;
    assign driveExchange = exchange_q;
    assign softReset = softReset_q;
    assign lowPower = lowPower_q;
    assign precompSelect = precomp_q;
    // Only the low rate bit leaves the block
    assign lowerRateOut = rate_q[0];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_float_reads_ones: assert property (
        rdHit && pinsFloat |=> ioRValid && (ioRData == 8'hFF))
        else $error("floated read not all ones");

    a_window_decode: assert property (
        ioRead && !windowHit |=> !ioRValid)
        else $error("read outside window answered");

    a_main_status_read: assert property (
        rdHit && !pinsFloat && (offset == 3'h4) |=> ioRData == $past(engine.mainStatus))
        else $error("offset 4 read not main status");

    a_config_rate_write: assert property (
        wrConfig && !wrRate |=> (rate_q == $past(ioWData[1:0]))
        && (lowerRateOut == $past(ioWData[0])))
        else $error("offset 7 write did not set rate");

    a_dout_both_modes: assert property (
        wrDout ##1 !wrDout ##1 (rdHit && !pinsFloat && (offset == 3'h2))
        |=> ioRData == $past(ioWData, 3))
        else $error("output control read back wrong");

    a_status_ps2_only: assert property (
        rdHit && !pinsFloat && !ps2Mode && (offset <= 3'h1) |=> ioRData == 8'hFF)
        else $error("status A/B visible outside PS/2");

    a_input_at_mode: assert property (
        rdHit && !pinsFloat && !ps2Mode && (offset == 3'h7)
        |=> (ioRData[6:0] == 7'h00) && (ioRData[7] == $past(pinSync.diskChangedFlag)))
        else $error("PC-AT input read shows more than disk change");

    a_tape_enhanced: assert property (
        rdHit && !pinsFloat && enhancedTapeLayoutMode && (offset == 3'h3)
        |=> ioRData[7] && (ioRData[6] == $past(pinSync.mediaSenseInA)))
        else $error("enhanced tape layout wrong");

    a_mfm_capture: assert property (
        mfmLoad |=> mfmMode == $past(ioWData[6]))
        else $error("density bit not captured");

    a_unassigned_quiet: assert property (
        wrHit && (offset == 3'h6) |=> $stable(dout_q) && $stable(rate_q) && $stable(tapeSel_q)
        && $stable(mfm_q) && $stable(firstByte_q) && !softReset)
        else $error("offset 6 write changed state");

    c_mfm_command: cover property (mfmLoad && ioWData[6]);
    c_floated_read: cover property (rdHit && pinsFloat);
    c_ps2_input_read: cover property (rdHit && ps2Mode && (offset == 3'h7));
    c_soft_reset: cover property (softReset);
endmodule : fdchr_regs
`default_nettype wire

/* fdchr_host.sv */
// Host model issuing byte reads and writes
`timescale 1ns/10ps
`default_nettype none
module fdchr_host (
    input wire logic sys_clk,
    output logic [15:0] ioAddr,
    output logic ioRead,
    output logic ioWrite,
    output logic [7:0] ioWData,
    input wire logic [7:0] ioRData,
    input wire logic ioRValid
);
    initial begin
        ioAddr = 16'h0000;
        ioRead = 1'b0;
        ioWrite = 1'b0;
        ioWData = 8'h00;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        ioAddr = a;
        ioWData = d;
        ioWrite = 1'b1;
        @(negedge sys_clk);
        ioWrite = 1'b0;
        ioAddr = ~a;
        ioWData = ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        ioAddr = a;
        ioRead = 1'b1;
        @(negedge sys_clk);
        ioRead = 1'b0;
        ioAddr = ~a;
        v = ioRValid;
        d = ioRData;
    endtask : rd
endmodule : fdchr_host
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the host register front end
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [15:0] WIN = 16'h03F0;
    logic sys_clk;
    logic rst;
    logic ps2Mode;
    logic enhMode;
    logic pinsFloat;
    logic [15:0] ioAddr;
    logic ioRead, ioWrite, ioRValid, mfmMode, lowerRateOut;
    logic [7:0] ioWData, ioRData, cmdByte;
    logic [3:0] motorEnable;
    logic [1:0] driveSelect, tapeSelect, driveExchange;
    logic dmaEnable, ctlReset_n, softReset, lowPower;
    logic [2:0] precompSelect;
    fdchr_pkg::fdchr_pins_t drivePins;
    fdchr_pkg::fdchr_eng_t engine;
    int nErrors = 0;
    int samplesChecked = 0;

    // Low base bits set on purpose: they must be ignored
    fdchr_regs fdchr_regs_i (
        .sys_clk(sys_clk), .rst(rst), .baseAddr(16'h03F5), .ioAddr(ioAddr),
        .ioRead(ioRead), .ioWrite(ioWrite), .ioWData(ioWData), .ioRData(ioRData),
        .ioRValid(ioRValid), .ps2Mode(ps2Mode), .enhancedTapeLayoutMode(enhMode),
        .pinsFloat(pinsFloat), .driveId(2'h2), .drivePins(drivePins), .engine(engine),
        .fifoWriteStrobe(), .fifoReadStrobe(), .cmdByte(cmdByte), .mfmMode(mfmMode),
        .motorEnable(motorEnable), .dmaEnable(dmaEnable), .controllerReset_n(ctlReset_n),
        .driveSelect(driveSelect), .tapeSelect(tapeSelect), .driveExchange(driveExchange),
        .softReset(softReset), .lowPower(lowPower), .precompSelect(precompSelect),
        .lowerRateOut(lowerRateOut)
    );

    fdchr_host fdchr_host_i (
        .sys_clk(sys_clk), .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
        .ioWData(ioWData), .ioRData(ioRData), .ioRValid(ioRValid)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic rdChk(input string nm, input logic [2:0] off, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        fdchr_host_i.rd({WIN[15:3], off}, d, v);
        check({nm, " valid"}, {7'h00, v}, 8'h01);
        check(nm, d, exp);
    endtask : rdChk

    task automatic wrOff(input logic [2:0] off, input logic [7:0] d);
        fdchr_host_i.wr({WIN[15:3], off}, d);
    endtask : wrOff

    task automatic summarize();
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic tReset();
        rdChk("dout rst", 3'h2, 8'h00);
        rdChk("din rst", 3'h7, 8'h85);
    endtask : tReset

    task automatic tDecode();
        logic [7:0] d;
        logic v;
        fdchr_host_i.wr(16'h03FA, 8'hFF);
        fdchr_host_i.rd(16'h03FA, d, v);
        check("outside valid", {7'h00, v}, 8'h00);
        wrOff(3'h6, 8'hFF);
        rdChk("dout kept", 3'h2, 8'h00);
        wrOff(3'h2, 8'h3D);
        check("motors", {4'h0, motorEnable}, 8'h03);
        check("dsel", {6'h00, driveSelect}, 8'h01);
        check("dma", {7'h00, dmaEnable}, 8'h01);
        check("ctl reset", {7'h00, ctlReset_n}, 8'h01);
        rdChk("dout", 3'h2, 8'h3D);
    endtask : tDecode

    task automatic tSplit();
        rdChk("main status", 3'h4, 8'hA5);
        wrOff(3'h4, 8'hDB);
        check("rate pin", {7'h00, lowerRateOut}, 8'h01);
        check("soft reset", {7'h00, softReset}, 8'h01);
        check("low power", {7'h00, lowPower}, 8'h01);
        check("precomp", {5'h00, precompSelect}, 8'h06);
        rdChk("din rate3", 3'h7, 8'h86);
        wrOff(3'h7, 8'h01);
        check("soft reset end", {7'h00, softReset}, 8'h00);
        check("low power kept", {7'h00, lowPower}, 8'h01);
        rdChk("din rate1", 3'h7, 8'h83);
        rdChk("main kept", 3'h4, 8'hA5);
    endtask : tSplit

    task automatic tModes();
        rdChk("sta ps2", 3'h0, 8'h8E);
        rdChk("stb ps2", 3'h1, 8'h33);
        @(negedge sys_clk);
        ps2Mode = 1'b0;
        rdChk("sta at", 3'h0, 8'hFF);
        rdChk("stb at", 3'h1, 8'hFF);
        rdChk("din at", 3'h7, 8'h80);
        rdChk("dout at", 3'h2, 8'h3D);
    endtask : tModes

    task automatic tTape();
        wrOff(3'h3, 8'hFF);
        rdChk("tape std", 3'h3, 8'h03);
        check("exch std", {6'h00, driveExchange}, 8'h00);
        @(negedge sys_clk);
        enhMode = 1'b1;
        rdChk("tape enh", 3'h3, 8'hE3);
        wrOff(3'h3, 8'h0E);
        rdChk("tape exch", 3'h3, 8'hEE);
        check("tape sel", {6'h00, tapeSelect}, 8'h02);
        check("exch pins", {6'h00, driveExchange}, 8'h03);
    endtask : tTape

    task automatic tFloat();
        @(negedge sys_clk);
        pinsFloat = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i != 6) begin
                rdChk("float", i[2:0], 8'hFF);
            end
        end
        @(negedge sys_clk);
        pinsFloat = 1'b0;
    endtask : tFloat

    task automatic tDensity();
        wrOff(3'h5, 8'h46);
        check("mfm", {7'h00, mfmMode}, 8'h01);
        check("cmd", cmdByte, 8'h46);
        wrOff(3'h5, 8'h06);
        check("fm", {7'h00, mfmMode}, 8'h00);
        // With the engine busy, the byte after a command byte is a parameter, which must not touch density
        @(negedge sys_clk);
        engine.cmdIdle = 1'b0;
        wrOff(3'h5, 8'h46);
        wrOff(3'h5, 8'h06);
        check("second byte", {7'h00, mfmMode}, 8'h01);
        check("cmd last", cmdByte, 8'h06);
        @(negedge sys_clk);
        engine.cmdIdle = 1'b1;
    endtask : tDensity

    initial begin
        rst = 1'b1;
        ps2Mode = 1'b1;
        enhMode = 1'b0;
        pinsFloat = 1'b0;
        drivePins = 6'h2B;
        // Command engine idle so every offset 5 write is a first byte, except the second tDensity write made with cmdIdle low
        engine = {7'h55, 8'hA5, 8'h3C};
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        tReset();
        tDecode();
        tSplit();
        tModes();
        tTape();
        tFloat();
        tDensity();
        summarize();
    end

    // About 100 cycles are needed; the margin covers slow decode paths
    initial begin
        repeat (5000) @(posedge sys_clk);
        nErrors++;
        summarize();
    end
endmodule : tb
`default_nettype wire
